// *** rtl/essc_pkg.sv ***
// Constants and types of the E1 sync status code transceiver
package essc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [9:0] IDX_CTRL  = 10'h170;
  localparam logic [9:0] IDX_RXC   = 10'h171;
  localparam logic [9:0] IDX_EXPA  = 10'h172;
  localparam logic [9:0] IDX_EXPB  = 10'h173;
  localparam logic [9:0] IDX_EXPC  = 10'h174;
  localparam logic [9:0] IDX_TXC   = 10'h175;
  localparam logic [9:0] IDX_REP   = 10'h176;
  localparam logic [9:0] IDX_ISTAT = 10'h17A;
  localparam logic [9:0] IDX_IMASK = 10'h17B;

  // ==========================================================
  // Control register field positions
  localparam int CB_SEND    = 0;
  localparam int CB_RFILT   = 1;
  localparam int CB_URST    = 3;
  localparam int CB_RXEN    = 4;
  localparam int CB_MFILT   = 5;
  localparam int CB_CARRIER = 7;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_REP  = 8'h01;
  localparam logic [3:0] RST_CODE = 4'h0;

  // ==========================================================
  // Code slots inside the CRC multiframe
  localparam logic [3:0] FRM_FIRST = 4'h2;
  localparam logic [3:0] FRM_LAST  = 4'h5;

  // ==========================================================
  // Quality codes
  // Fixed four-bit quality values
  localparam logic [3:0] QL_UNKNOWN = 4'h0;
  localparam logic [3:0] QL_PRS     = 4'h2;
  localparam logic [3:0] QL_SSU_A   = 4'h4;
  localparam logic [3:0] QL_SSU_B   = 4'h8;
  localparam logic [3:0] QL_SETS    = 4'hB;
  localparam logic [3:0] QL_DNU     = 4'hF;

  // ==========================================================
  // Interrupt status bit positions
  localparam int IB_RXVALID = 0;
  localparam int IB_COS     = 1;
  localparam int IB_MATCHA  = 2;
  localparam int IB_MATCHB  = 3;
  localparam int IB_MATCHC  = 4;
  localparam int IB_TXDONE  = 5;
  localparam int INT_W      = 6;

  // Transmitter states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b10,
    TX_ONES = 2'b11
  } essc_tx_st_t;

endpackage : essc_pkg

// *** rtl/essc_transceiver.sv ***
// E1 sync status code transceiver with Avalon-MM register slave
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
module essc_transceiver
  import essc_pkg::*;
(
  input  wire logic        core_clk_i,        // 40 MHz core clock
  input  wire logic        rst_i,             // Synchronous reset
  input  wire logic        ce_i,              // Clock enable
  input  wire logic [11:0] address_i,         // Byte address
  input  wire logic        read_i,            // Read request
  input  wire logic        write_i,           // Write request
  input  wire logic [31:0] writedata_i,       // Write data
  input  wire logic [3:0]  byteenable_i,      // Byte lanes
  output logic      [31:0] readdata_o,        // Read data
  output logic             waitrequest_o,     // Slave stall
  input  wire logic        tx_frame_start_i,  // Transmit frame begins
  input  wire logic [3:0]  tx_frame_num_i,    // Its multiframe number
  input  wire logic        rx_bit_strobe_i,   // Receive carrier bits valid
  input  wire logic [3:0]  rx_frame_num_i,    // Their multiframe number
  input  wire logic        rx_sa_bit_i,       // Selected national bit
  input  wire logic        rx_si_bit_i,       // Received Si bit
  output logic             tx_code_bit_o,     // Code bit for this frame
  output logic             tx_sa_insert_o,    // Override national bit
  output logic             tx_si_insert_o,    // Override Si bit
  output logic             irq_o              // Level interrupt
);

  // ==========================================================
  // State
  typedef struct packed {
    logic              carrier_si;   // Carrier select
    logic [1:0]        match_filt;   // Match filter count
    logic              rx_en;        // Receiver enable
    logic [1:0]        rx_filt;      // Receive filter count
    logic [3:0]        prev_code;    // Previous received code
    logic [3:0]        cur_code;     // Current received code
    logic [3:0]        exp_a;        // Expected code a
    logic [3:0]        exp_b;        // Expected code b
    logic [3:0]        exp_c;        // Expected code c
    logic [3:0]        tx_code;      // Transmit code value
    logic [7:0]        rep_count;    // Transmit repeat count
    logic [INT_W-1:0]  int_stat;     // Sticky events
    logic [INT_W-1:0]  int_mask;     // Event mask
    essc_tx_st_t       tx_st;        // Transmitter state
    logic [3:0]        tx_shift;     // Latched code in flight
    logic [7:0]        reps_left;    // Repetitions remaining
    logic              tx_cont;      // Continuous mode
    logic [2:0]        rx_shift;     // Partial received nibble
    logic [3:0]        cand;         // Candidate code
    logic [2:0]        cand_cnt;     // Consecutive repeats
    logic              waitreq;      // Bus stall
    logic [31:0]       rdata;        // Bus read data
    logic              irq;          // Interrupt flop
    logic              tx_bit;       // Outgoing code bit
    logic              sa_ins;       // National override
    logic              si_ins;       // Si override
  } essc_state_t;

  essc_state_t q;   // Registered state
  essc_state_t d;   // Next state

  // ==========================================================
  // Helpers
  // Filter field to needed consecutive count
  function automatic logic [2:0] need_cnt(input logic [1:0] sel);
    unique case (sel)
      2'b00: need_cnt = 3'h1;
      2'b01: need_cnt = 3'h3;
      2'b10: need_cnt = 3'h5;
      2'b11: need_cnt = 3'h7;
    endcase
  endfunction : need_cnt

  // True once when a run first reaches its threshold
  function automatic logic qual_fire(input logic       same,
                                     input logic [2:0] cnt_old,
                                     input logic [2:0] cnt_new,
                                     input logic [1:0] sel);
    qual_fire = (cnt_new == need_cnt(sel)) &&
                !(same && (cnt_old == need_cnt(sel)));
  endfunction : qual_fire

  // Register read mux
  function automatic logic [31:0] reg_read(input essc_state_t s,
                                           input logic [9:0]  idx);
    reg_read = 32'h0000_0000;
    unique case (idx)
      IDX_CTRL:  reg_read[7:0] = {s.carrier_si, s.match_filt, s.rx_en,
                                  1'b0, s.rx_filt, 1'b0};
      IDX_RXC:   reg_read[7:0] = {s.prev_code, s.cur_code};
      IDX_EXPA:  reg_read[3:0] = s.exp_a;
      IDX_EXPB:  reg_read[3:0] = s.exp_b;
      IDX_EXPC:  reg_read[3:0] = s.exp_c;
      IDX_TXC:   reg_read[3:0] = s.tx_code;
      IDX_REP:   reg_read[7:0] = s.rep_count;
      IDX_ISTAT: reg_read[INT_W-1:0] = s.int_stat;
      IDX_IMASK: reg_read[INT_W-1:0] = s.int_mask;
      default:   reg_read = 32'h0000_0000;
    endcase
  endfunction : reg_read

  // ==========================================================
  // Combinational next state
  logic             wr_go;     // Write commits this edge
  logic             unit_rst;  // Code unit reset request
  logic             send;      // Send request
  logic [INT_W-1:0] ev;        // Events this cycle
  logic [INT_W-1:0] clr;       // Write-one-to-clear mask
  logic             tx_slot;   // Transmit frame holds a code bit
  logic [1:0]       tx_idx;    // Bit index in that frame
  logic             rx_slot;   // Receive frame holds a code bit
  logic             rx_val;    // Received carrier bit
  logic [3:0]       nib;       // Completed nibble
  logic             same;      // Nibble equals candidate
  logic [2:0]       cnt_n;     // Next consecutive count
  logic             mfire;     // Match filter satisfied

  always_comb begin
    d        = q;
    ev       = '0;
    clr      = '0;
    unit_rst = 1'b0;
    send     = 1'b0;
    wr_go    = write_i && !q.waitreq && byteenable_i[0];
    tx_slot  = (tx_frame_num_i >= FRM_FIRST) &&
               (tx_frame_num_i <= FRM_LAST);
    tx_idx   = 2'(tx_frame_num_i - FRM_FIRST);
    rx_slot  = (rx_frame_num_i >= FRM_FIRST) &&
               (rx_frame_num_i <= FRM_LAST);
    // Code rides national bit or Si
    rx_val   = q.carrier_si ? rx_si_bit_i : rx_sa_bit_i;
    nib      = {q.rx_shift, rx_val};
    same     = (nib == q.cand);
    cnt_n    = same ? ((q.cand_cnt == 3'h7) ? 3'h7 : q.cand_cnt + 3'h1)
                    : 3'h1;
    mfire    = 1'b0;

    // Bus handshake: one stall cycle, then answer
    if ((read_i || write_i) && q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = reg_read(q, address_i[11:2]);
    end else begin
      d.waitreq = 1'b1;
    end

    // Register writes
    if (wr_go) begin
      unique case (address_i[11:2])
        IDX_CTRL: begin
          d.carrier_si = writedata_i[CB_CARRIER];
          d.match_filt = writedata_i[CB_MFILT +: 2];
          d.rx_en      = writedata_i[CB_RXEN];
          d.rx_filt    = writedata_i[CB_RFILT +: 2];
          unit_rst     = writedata_i[CB_URST];
          send         = writedata_i[CB_SEND];
        end
        IDX_EXPA:  d.exp_a     = writedata_i[3:0];
        IDX_EXPB:  d.exp_b     = writedata_i[3:0];
        IDX_EXPC:  d.exp_c     = writedata_i[3:0];
        IDX_TXC:   d.tx_code   = writedata_i[3:0];
        IDX_REP:   d.rep_count = writedata_i[7:0];
        IDX_ISTAT: clr         = writedata_i[INT_W-1:0];
        IDX_IMASK: d.int_mask  = writedata_i[INT_W-1:0];
        default: begin
          // Read-only or unmapped: ignored
        end
      endcase
    end

    // Transmitter, stepped once per transmit frame
    if (tx_frame_start_i) begin
      d.sa_ins = 1'b0;
      d.si_ins = 1'b0;
      d.tx_bit = 1'b1;
      unique case (q.tx_st)
        TX_IDLE: begin
          // Nothing inserted
        end
        TX_WAIT, TX_SEND: begin
          // First bit in frame two, MSB first
          if ((q.tx_st == TX_SEND && tx_slot) ||
              tx_frame_num_i == FRM_FIRST) begin
            d.tx_st  = TX_SEND;
            d.tx_bit = q.tx_shift[2'd3 - tx_idx];
            d.sa_ins = !q.carrier_si;
            d.si_ins = q.carrier_si;
            if (tx_frame_num_i == FRM_LAST && !q.tx_cont) begin
              d.reps_left = q.reps_left - 8'h01;
              if (q.reps_left == 8'h01) begin
                d.tx_st          = TX_ONES;
                ev[IB_TXDONE]    = 1'b1;
              end
            end
          end
        end
        TX_ONES: begin
          if (tx_slot) begin
            d.sa_ins = !q.carrier_si;
            d.si_ins = q.carrier_si;
          end
        end
      endcase
    end

    // Send starts from the stored code
    if (send) begin
      d.tx_st     = TX_WAIT;
      d.tx_shift  = q.tx_code;
      d.reps_left = q.rep_count;
      d.tx_cont   = (q.rep_count == 8'h00);
    end

    if (rx_bit_strobe_i && rx_slot && q.rx_en) begin
      d.rx_shift = nib[2:0];
      if (rx_frame_num_i == FRM_LAST) begin
        d.cand     = nib;
        d.cand_cnt = cnt_n;
        if (qual_fire(same, q.cand_cnt, cnt_n, q.rx_filt)) begin
          d.prev_code      = q.cur_code;
          d.cur_code       = nib;
          ev[IB_RXVALID]   = 1'b1;
          // Change alarm only on a new value
          ev[IB_COS]       = (nib != q.cur_code);
        end
        mfire = qual_fire(same, q.cand_cnt, cnt_n, q.match_filt);
        ev[IB_MATCHA] = mfire && (nib == q.exp_a);
        ev[IB_MATCHB] = mfire && (nib == q.exp_b);
        ev[IB_MATCHC] = mfire && (nib == q.exp_c);
      end
    end

    if (unit_rst) begin
      {d.carrier_si, d.match_filt, d.rx_en} = RST_CTRL[7:4];
      d.rx_filt   = RST_CTRL[2:1];
      d.prev_code = RST_CODE;
      d.cur_code  = RST_CODE;
      d.exp_a     = RST_CODE;
      d.exp_b     = RST_CODE;
      d.exp_c     = RST_CODE;
      d.tx_code   = RST_CODE;
      d.rep_count = RST_REP;
      d.tx_st     = TX_IDLE;
      d.tx_shift  = RST_CODE;
      d.reps_left = 8'h00;
      d.tx_cont   = 1'b0;
      d.rx_shift  = 3'h0;
      d.cand      = RST_CODE;
      d.cand_cnt  = 3'h0;
      d.sa_ins    = 1'b0;
      d.si_ins    = 1'b0;
      d.tx_bit    = 1'b1;
      ev          = '0;
    end

    // Sticky status, set wins over clear
    d.int_stat = (q.int_stat & ~clr) | ev;
    d.irq      = |(d.int_stat & d.int_mask);
  end

  // ==========================================================
  // State register
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      q           <= '0;
      q.waitreq   <= 1'b1;
      q.rep_count <= RST_REP;
      q.tx_bit    <= 1'b1;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign readdata_o     = q.rdata;
  assign waitrequest_o  = q.waitreq;
  assign tx_code_bit_o  = q.tx_bit;
  assign tx_sa_insert_o = q.sa_ins;
  assign tx_si_insert_o = q.si_ins;
  assign irq_o          = q.irq;

  // ==========================================================
  // Checks
  logic ctrl_wr;   // Control write commits
  assign ctrl_wr = ce_i && wr_go && (address_i[11:2] == IDX_CTRL);

  AST_SEND_ARMS: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl_wr && writedata_i[CB_SEND] && !writedata_i[CB_URST]
    |=> q.tx_st == TX_WAIT && q.tx_shift == $past(q.tx_code))
    else $error("send did not arm transmitter");

  AST_MSB_FIRST: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && tx_frame_start_i && tx_frame_num_i == FRM_FIRST &&
    q.tx_st == TX_WAIT && !unit_rst && !send
    |=> tx_code_bit_o == $past(q.tx_shift[3]) &&
        (tx_sa_insert_o || tx_si_insert_o))
    else $error("first code bit not MSB in frame two");

  AST_ONE_CARRIER: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(tx_sa_insert_o && tx_si_insert_o))
    else $error("both carriers overridden");

  AST_RX_OFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !q.rx_en && !ctrl_wr |=> $stable(q.cur_code))
    else $error("code changed while receiver disabled");

  AST_PREV_SHIFT: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && d.cur_code != q.cur_code && !unit_rst
    |=> q.prev_code == $past(q.cur_code))
    else $error("previous code not kept");

  AST_RX_FILTER: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && ev[IB_RXVALID] && !unit_rst
    |=> q.cand_cnt == need_cnt($past(q.rx_filt)))
    else $error("code updated before filter count");

  AST_MATCH_A: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(q.int_stat[IB_MATCHA])
    |-> q.cand == q.exp_a && q.cand_cnt == need_cnt(q.match_filt))
    else $error("match alarm without qualified match");

  AST_COS_DIFF: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ce_i && ev[IB_COS] |=> q.cur_code != q.prev_code)
    else $error("change alarm on repeated code");

  AST_UNIT_RST: assert property (@(posedge core_clk_i) disable iff (rst_i)
    ctrl_wr && writedata_i[CB_URST]
    |=> q.cur_code == RST_CODE && q.tx_st == TX_IDLE &&
        q.rep_count == RST_REP &&
        q.int_mask == $past(q.int_mask))
    else $error("unit reset incomplete");

  AST_CONT_MODE: assert property (@(posedge core_clk_i) disable iff (rst_i)
    q.tx_cont && q.tx_st == TX_SEND && !ctrl_wr
    |=> q.tx_st != TX_ONES)
    else $error("continuous mode stopped");

  COV_TX_DONE: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(q.int_stat[IB_TXDONE]));
  COV_COS: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(q.int_stat[IB_COS]));
  COV_MATCH: cover property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(q.int_stat[IB_MATCHC]) && irq_o);

endmodule : essc_transceiver

// *** test/essc_far_end.sv ***
// Far-end E1 terminal model: frame timing, received codes, tx capture
`timescale 1ns/1ps
module essc_far_end (
  input  wire logic       clk_i,        // Core clock
  input  wire logic       rst_i,        // Synchronous reset
  input  wire logic [3:0] code_i,       // Code sent towards the block
  input  wire logic       tx_bit_i,     // Code bit from the block
  input  wire logic       sa_ins_i,     // National bit override
  input  wire logic       si_ins_i,     // Si override
  output logic            frm_start_o,  // Transmit frame pulse
  output logic      [3:0] frm_num_o,    // Frame number, both ways
  output logic            rx_stb_o,     // Receive bits valid
  output logic            rx_sa_o,      // National bit to the block
  output logic            rx_si_o,      // Si bit to the block
  output logic      [3:0] tx_nib_o,     // Last captured nibble
  output logic            sa_full_o,    // All four slots on national
  output logic            si_full_o,    // All four slots on Si
  output logic      [7:0] mf_o          // Multiframe counter
);
  logic [1:0] cnt_q;  // Cycle within a frame
  logic [3:0] bit_q;  // Captured code bits
  logic [3:0] sak_q;  // National override flags
  logic [3:0] sik_q;  // Si override flags
  logic       slot;   // Frame carries a code bit

  // ==========================================================
  // Frame timing, four cycles a frame
  // frames numbered by a running CRC multiframe
  assign slot        = (frm_num_o >= 4'h2) && (frm_num_o <= 4'h5);
  assign frm_start_o = (cnt_q == 2'h0);
  assign rx_stb_o    = (cnt_q == 2'h1);
  // code on Si, inverse on the one national bit
  assign rx_si_o = slot ? code_i[3'h5 - frm_num_o[2:0]] : frm_num_o[0];
  assign rx_sa_o = slot ? ~code_i[3'h5 - frm_num_o[2:0]] : ~frm_num_o[0];

  // Counters and capture of inserted bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q     <= 2'h0;
      frm_num_o <= 4'h0;
      mf_o      <= 8'h00;
      bit_q     <= 4'h0;
      sak_q     <= 4'h0;
      sik_q     <= 4'h0;
      tx_nib_o  <= 4'h0;
      sa_full_o <= 1'b0;
      si_full_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      // Last cycle of a frame
      if (cnt_q == 2'h3) begin
        frm_num_o <= frm_num_o + 4'h1;
        if (frm_num_o == 4'hF) begin
          mf_o <= mf_o + 8'h01;
        end
        if (slot) begin
          bit_q <= {bit_q[2:0], tx_bit_i};
          sak_q <= {sak_q[2:0], sa_ins_i};
          sik_q <= {sik_q[2:0], si_ins_i};
        end
        if (frm_num_o == 4'h5) begin
          tx_nib_o  <= {bit_q[2:0], tx_bit_i};
          sa_full_o <= &{sak_q[2:0], sa_ins_i};
          si_full_o <= &{sik_q[2:0], si_ins_i};
        end
      end
    end
  end
endmodule : essc_far_end

// *** test/tb.sv ***
// Self-checking testbench of the sync status code transceiver
`timescale 1ns/1ps
module tb;
  import essc_pkg::*;
  logic        clk = 1'b0;         // Core clock
  logic        rst = 1'b1;         // Reset
  logic        ce = 1'b1;          // Clock enable
  logic [11:0] addr = 12'h000;     // Byte address
  logic        rd = 1'b0;          // Read request
  logic        wr = 1'b0;          // Write request
  logic [31:0] wdata = 32'h0;      // Write data
  logic [31:0] rdata;              // Read data
  logic        waitreq;            // Slave stall
  logic        fstart, rstb;       // Frame pulses
  logic [3:0]  fnum;               // Frame number
  logic        rsa, rsi;           // Received carrier bits
  logic        tbit, tsa, tsi;     // Transmit outputs
  logic        irq;                // Interrupt
  logic [3:0]  code = QL_PRS;      // Code sent by far end
  logic [3:0]  nib;                // Captured nibble
  logic        sa_full, si_full;   // Captured override flags
  logic [7:0]  mf;                 // Multiframe count
  int          error_cnt = 0;      // Mismatches
  int          n_tests = 0;        // Comparisons

  // Clock, 25 ns period
  always #12.5 clk = ~clk;

  essc_transceiver dut_u (.core_clk_i(clk), .rst_i(rst), .ce_i(ce),
    .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdata),
    .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(waitreq),
    .tx_frame_start_i(fstart), .tx_frame_num_i(fnum),
    .rx_bit_strobe_i(rstb), .rx_frame_num_i(fnum), .rx_sa_bit_i(rsa),
    .rx_si_bit_i(rsi), .tx_code_bit_o(tbit), .tx_sa_insert_o(tsa),
    .tx_si_insert_o(tsi), .irq_o(irq));

  essc_far_end far_u (.clk_i(clk), .rst_i(rst), .code_i(code),
    .tx_bit_i(tbit), .sa_ins_i(tsa), .si_ins_i(tsi),
    .frm_start_o(fstart), .frm_num_o(fnum), .rx_stb_o(rstb),
    .rx_sa_o(rsa), .rx_si_o(rsi), .tx_nib_o(nib),
    .sa_full_o(sa_full), .si_full_o(si_full), .mf_o(mf));

  // ==========================================================
  // Verdict and end of run
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [9:0] idx, input logic is_wr,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    addr  <= {idx, 2'b00};
    rd    <= ~is_wr;
    wr    <= is_wr;
    wdata <= {24'h0, d};
    do @(posedge clk); while (waitreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // Register write
  task automatic wreg(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(idx, 1'b1, d, q);
  endtask : wreg

  // Register read and compare
  task automatic rchk(input logic [9:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(idx, 1'b0, 8'h00, q);
    chk(q, e);
  endtask : rchk

  // Wait for n multiframe boundaries
  task automatic wait_mf(input int n);
    logic [7:0] old;
    repeat (n) begin
      old = mf;
      while (mf === old) @(posedge clk);
    end
  endtask : wait_mf

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rchk(IDX_CTRL, RST_CTRL);                  // control default
    rchk(IDX_REP, RST_REP);                    // count default
    rchk(10'h17F, 8'h00);                      // unmapped reads zero
    wreg(IDX_RXC, 8'h5A);
    rchk(IDX_RXC, 8'h00);                      // read only
    wreg(IDX_EXPA, {4'h0, QL_PRS});
    wreg(IDX_EXPB, {4'h0, QL_SSU_A});
    wreg(IDX_EXPC, {4'h0, QL_DNU});
    rchk(IDX_EXPC, {4'h0, QL_DNU});            // expected storage
    // National bit, one repetition then all ones
    wreg(IDX_TXC, {4'h0, QL_SETS});
    wait_mf(1);
    wreg(IDX_CTRL, 8'h01);
    rchk(IDX_CTRL, 8'h00);                     // send self clears
    wait_mf(1);
    chk({sa_full, si_full, 2'h0, nib}, {4'h8, QL_SETS});
    wait_mf(1);
    chk({sa_full, si_full, 2'h0, nib}, 8'h8F); // ones follow
    rchk(IDX_ISTAT, 8'h20);                    // done event
    wreg(IDX_ISTAT, 8'h20);
    rchk(IDX_ISTAT, 8'h00);                    // status cleared
    // Si carrier, continuous repetition
    wreg(IDX_REP, 8'h00);
    wreg(IDX_TXC, {4'h0, QL_SSU_B});
    wait_mf(1);
    wreg(IDX_CTRL, 8'h81);
    wait_mf(1);
    chk({sa_full, si_full, 2'h0, nib}, {4'h4, QL_SSU_B}); // Si
    wait_mf(1);
    chk({sa_full, si_full, 2'h0, nib}, {4'h4, QL_SSU_B}); // endless
    // Receive on Si, filter three, match filter five
    wreg(IDX_IMASK, 8'h02);
    wait_mf(1);
    wreg(IDX_CTRL, 8'hD2);
    rchk(IDX_CTRL, 8'hD2);                     // fields
    wait_mf(2);
    rchk(IDX_RXC, 8'h00);                      // two not enough
    wait_mf(1);
    rchk(IDX_RXC, {4'h0, QL_PRS});             // third updates
    rchk(IDX_ISTAT, 8'h03);                    // change event
    chk({7'h0, irq}, 8'h01);                   // unmasked level
    wait_mf(2);
    code <= QL_SSU_A;
    rchk(IDX_ISTAT, 8'h07);                    // fifth matches
    wreg(IDX_ISTAT, 8'h07);
    rchk(IDX_ISTAT, 8'h00);                    // status cleared
    chk({7'h0, irq}, 8'h00);                   // level drops
    wait_mf(3);
    rchk(IDX_RXC, {QL_PRS, QL_SSU_A});         // previous moves up
    rchk(IDX_ISTAT, 8'h03);                    // match not yet
    wait_mf(2);
    rchk(IDX_ISTAT, 8'h0B);                    // second match alarm
    wreg(IDX_ISTAT, 8'h0B);
    wait_mf(2);
    rchk(IDX_ISTAT, 8'h00);                    // repeat no event
    // Receiver off
    code <= QL_DNU;
    wreg(IDX_CTRL, 8'h80);
    wait_mf(2);
    rchk(IDX_RXC, {QL_PRS, QL_SSU_A});         // disabled holds
    rchk(IDX_ISTAT, 8'h00);                    // no events
    // Unit reset
    wreg(IDX_CTRL, 8'h08);
    rchk(IDX_CTRL, 8'h00);                     // control cleared
    rchk(IDX_EXPA, 8'h00);                     // expected cleared
    rchk(IDX_REP, RST_REP);                    // count restored
    rchk(IDX_RXC, 8'h00);                      // codes cleared
    rchk(IDX_IMASK, 8'h02);                    // mask kept
    wait_mf(2);
    chk({sa_full, si_full, 6'h0}, 8'h00);      // transmit stopped
    // National receive, no receive filter, match filter seven
    code <= 4'h0;
    wreg(IDX_EXPC, {4'h0, QL_DNU});
    wreg(IDX_IMASK, 8'h10);
    wait_mf(1);
    wreg(IDX_CTRL, 8'h70);
    wait_mf(1);
    rchk(IDX_RXC, {4'h0, QL_DNU});             // first updates
    rchk(IDX_ISTAT, 8'h03);                    // events
    wreg(IDX_ISTAT, 8'h03);
    // Clock enable low freezes one whole multiframe
    wait_mf(1);
    ce <= 1'b0;
    wait_mf(1);
    ce <= 1'b1;
    wait_mf(4);
    rchk(IDX_ISTAT, 8'h00);                    // six not seven
    chk({7'h0, irq}, 8'h00);                   // no match level
    wait_mf(1);
    rchk(IDX_ISTAT, 8'h10);                    // seventh matches
    chk({7'h0, irq}, 8'h01);                   // match level
    close_out();
  end
endmodule : tb
